/* hw/gpc_consts.svh */
// constants for the three-port pin controller
// assumes a 32-bit apb slave with word-aligned registers
`ifndef GPC_CONSTS_SVH
`define GPC_CONSTS_SVH

// mode codes
`define GPC_MODE_ANALOG 4'h0
`define GPC_MODE_FLOAT 4'h4
`define GPC_MODE_PULL 4'h8
`define GPC_MODE_PP 4'h1
`define GPC_MODE_OD 4'h5
`define GPC_MODE_ALT_PP 4'h9
`define GPC_MODE_ALT_OD 4'hd
`define GPC_MODE_SPI_CLK 4'hb

// register offsets inside a port window, and the global window
`define GPC_OFF_CFGL 5'h00
`define GPC_OFF_CFGH 5'h04
`define GPC_OFF_IN 5'h08
`define GPC_OFF_OUT 5'h0c
`define GPC_OFF_SET 5'h10
`define GPC_OFF_CLR 5'h14
`define GPC_OFF_WAKE 5'h18
`define GPC_OFF_DBGCFG 5'h00
`define GPC_OFF_DBGSTAT 5'h04
`define GPC_GLOBAL_SEL 2'b11

// field positions
`define GPC_BIT_DBGDIS 0
`define GPC_BIT_EXTREG 1
`define GPC_BIT_BOOT 0

// pin indices, port a = 0..7, b = 8..15, c = 16..23
`define GPC_PIN_PA4 4
`define GPC_PIN_PA5 5
`define GPC_PIN_PA7 7
`define GPC_PIN_PB0 8
`define GPC_PIN_PC0 16
`define GPC_PIN_PC2 18
`define GPC_PIN_PC3 19
`define GPC_PIN_PC4 20
`define GPC_T2_A_CH1 5'd0
`define GPC_T2_A_CH2 5'd3
`define GPC_T2_A_CH3 5'd1
`define GPC_T2_A_CH4 5'd2
`define GPC_T2_B_BASE 5'd9

// reset values
`define GPC_CFG_RST 4'h4
`define GPC_EXTREG_RST 1'b1
`define GPC_DBGDIS_RST 1'b0
`define GPC_BOOT_RST 1'b1
`define GPC_PULL_RST 24'h00_0020

// startup delay in oscillator periods
`define GPC_STARTUP_PERIODS 512

`endif

/* hw/gpc_pkg.sv */
// types for the three-port pin controller
// assumes the constants header for field widths of registers
package gpc_pkg;
	typedef enum logic {PH_BOOT, PH_RUN} gpc_phase_t;

	typedef struct packed {
		gpc_phase_t phase;
		logic [9:0] boot_cnt;
		logic [23:0][3:0] mode;
		logic [23:0] dout;
		logic [23:0] wake;
		logic dbg_dis;
		logic extreg;
		logic boot_st;
		logic [23:0] sync1;
		logic [23:0] sync2;
		logic [23:0] pin_out;
		logic [23:0] pin_oe;
		logic [23:0] pull_up;
		logic [23:0] pull_dn;
		logic [23:0] analog;
		logic [23:0] periph_in;
		logic [31:0] prdata;
		logic pready;
		logic pslverr;
	} gpc_state_t;
endpackage

/* hw/gpc_port.sv */
// three 8-bit pin ports with mode codes, apb registers, forced functions and boot sampling
// assumes an apb master on clk, peripheral signals on clk, raw pin levels from outside
// Operation
// - four-bit mode code held per pin
// - code 0 analog, input reads one
// - code 4 floating input, no pulls
// - code 8 pulled input, output bit picks
// - codes 1/5 push-pull/open-drain from output register
// - codes 9/D driven by peripheral
// - code B special spi clock output
// - low register pins 3..0, high 7..4
// - set/clear registers change written-one bits
// - one output source per pin
// - digital input always to input and peripherals
// - enabled timer two beats serial output
// - option bits route timer channels a/b
// - pa4/pa5 carry packet or cpu trace
// - alternate pin without peripheral drives zero
// - debug disable frees debugger pins
// - regulator enable forces pa7 open-drain
// - jtag forces pc0/3/4 pulled inputs, pc2 output
// - serial wire makes pc4 bidirectional
// - chip reset: floating, regulator on, debug on
// - pa5 pulled up during startup delay
// - boot pin sampled then status kept
//
// Our own choices: the APB register port and the register offsets.
`timescale 1ns/1ps
`include "gpc_consts.svh"

module gpc_port
	import gpc_pkg::*;
#(
	parameter int STARTUP_CYCLES = `GPC_STARTUP_PERIODS,
	parameter logic [23:0] ALT_PRESENT = 24'hff_ffff
) (
	// clock, reset, enable
	input wire logic clk,
	input wire logic rst,
	input wire logic ce,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [11:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// pins
	input wire logic [23:0] pin_in,
	output logic [23:0] pin_out,
	output logic [23:0] pin_oe,
	output logic [23:0] pin_pull_up,
	output logic [23:0] pin_pull_down,
	output logic [23:0] pin_analog,
	// peripherals
	input wire logic [23:0] alt_out,
	output logic [23:0] periph_in,
	output logic [23:0] port_wake_monitor,
	input wire logic [3:0] timer_two_ch,
	input wire logic [3:0] timer_two_channel_enable_reg,
	input wire logic [3:0] timer_two_option_reg,
	input wire logic trace_sel,
	input wire logic packet_trace_enable,
	input wire logic packet_trace_data,
	input wire logic cpu_trace_data_bit_two,
	input wire logic cpu_trace_data_bit_three,
	// debugger and regulator
	input wire logic dbg_jtag_active,
	input wire logic dbg_swd_active,
	input wire logic test_data_output,
	input wire logic swdio_out,
	input wire logic swdio_oe,
	input wire logic reg_en,
	// boot status
	output logic boot_select_status_bit
);

	if (STARTUP_CYCLES < 3 || STARTUP_CYCLES > 1023) begin : g_chk
		$error("STARTUP_CYCLES out of range");
	end

	localparam logic [9:0] BOOT_LAST = 10'(STARTUP_CYCLES - 1);

	gpc_state_t s;
	gpc_state_t n;

	// timer two channel to pin index
	function automatic logic [4:0] tim_pin(input int ch, input logic route);
		logic [4:0] p;
		p = `GPC_T2_B_BASE + 5'(ch);
		if (!route) begin
			case (ch)
				0: p = `GPC_T2_A_CH1;
				1: p = `GPC_T2_A_CH2;
				2: p = `GPC_T2_A_CH3;
				default: p = `GPC_T2_A_CH4;
			endcase
		end
		return p;
	endfunction

	// alternate output value of one pin
	function automatic logic alt_val(input int i, input logic [23:0] ao, input logic [3:0] tch,
		input logic [3:0] ten, input logic [3:0] trt, input logic tsel, input logic [3:0] trc);
		logic v;
		logic hit;
		v = ALT_PRESENT[i] ? ao[i] : 1'b0;
		if (i == `GPC_PIN_PA4) begin
			v = tsel ? trc[2] : trc[0];
		end
		if (i == `GPC_PIN_PA5) begin
			v = tsel ? trc[3] : trc[1];
		end
		hit = 1'b0;
		for (int c = 0; c < 4; c++) begin
			if (ten[c] && !hit && tim_pin(c, trt[c]) == 5'(i)) begin
				v = tch[c];
				hit = 1'b1;
			end
		end
		return v;
	endfunction

	// register decode
	logic [1:0] a_port;
	logic [4:0] a_off;
	logic [4:0] a_base;
	logic a_hit;
	logic [31:0] a_rd;
	logic acc;
	logic wr;
	logic [3:0] trc;

	always_comb begin
		a_port = paddr[6:5];
		a_off = paddr[4:0];
		a_base = {a_port, 3'b000};
		a_hit = 1'b0;
		a_rd = 32'h0000_0000;
		if (paddr[11:7] == 5'h00) begin
			if (a_port == `GPC_GLOBAL_SEL) begin
				case (a_off)
					`GPC_OFF_DBGCFG: begin
						a_hit = 1'b1;
						a_rd[`GPC_BIT_DBGDIS] = s.dbg_dis;
						a_rd[`GPC_BIT_EXTREG] = s.extreg;
					end
					`GPC_OFF_DBGSTAT: begin
						a_hit = 1'b1;
						a_rd[`GPC_BIT_BOOT] = s.boot_st;
					end
					default: a_hit = 1'b0;
				endcase
			end else begin
				case (a_off)
					`GPC_OFF_CFGL: begin
						a_hit = 1'b1;
						for (int k = 0; k < 4; k++) begin
							a_rd[k*4 +: 4] = s.mode[a_base + k];
						end
					end
					`GPC_OFF_CFGH: begin
						a_hit = 1'b1;
						for (int k = 0; k < 4; k++) begin
							a_rd[k*4 +: 4] = s.mode[a_base + 4 + k];
						end
					end
					`GPC_OFF_IN: begin
						a_hit = 1'b1;
						a_rd[7:0] = s.periph_in[a_base +: 8];
					end
					`GPC_OFF_OUT: begin
						a_hit = 1'b1;
						a_rd[7:0] = s.dout[a_base +: 8];
					end
					`GPC_OFF_SET, `GPC_OFF_CLR: a_hit = 1'b1;
					`GPC_OFF_WAKE: begin
						a_hit = 1'b1;
						a_rd[7:0] = s.wake[a_base +: 8];
					end
					default: a_hit = 1'b0;
				endcase
			end
		end
		acc = psel && penable && !s.pready;
		wr = psel && penable && pwrite && s.pready && !s.pslverr;
		trc = {cpu_trace_data_bit_three, cpu_trace_data_bit_two, packet_trace_data, packet_trace_enable};
	end

	// next state
	always_comb begin
		logic [3:0] m;
		logic av;
		logic po;
		logic oe;
		logic pu;
		logic pd;
		logic an;
		logic dbg;
		logic jtag;
		logic swd;
		m = 4'h0;
		av = 1'b0;
		po = 1'b0;
		oe = 1'b0;
		pu = 1'b0;
		pd = 1'b0;
		an = 1'b0;
		dbg = 1'b0;
		jtag = 1'b0;
		swd = 1'b0;
		n = s;
		n.sync1 = pin_in;
		n.sync2 = s.sync1;
		// one wait state, answer registered
		n.pready = acc;
		n.pslverr = acc && !a_hit;
		n.prdata = acc ? a_rd : 32'h0000_0000;
		if (wr) begin
			if (a_port == `GPC_GLOBAL_SEL) begin
				if (a_off == `GPC_OFF_DBGCFG) begin
					n.dbg_dis = pwdata[`GPC_BIT_DBGDIS];
					n.extreg = pwdata[`GPC_BIT_EXTREG];
				end
			end else begin
				case (a_off)
					`GPC_OFF_CFGL: begin
						for (int k = 0; k < 4; k++) begin
							n.mode[a_base + k] = pwdata[k*4 +: 4];
						end
					end
					`GPC_OFF_CFGH: begin
						for (int k = 0; k < 4; k++) begin
							n.mode[a_base + 4 + k] = pwdata[k*4 +: 4];
						end
					end
					`GPC_OFF_OUT: n.dout[a_base +: 8] = pwdata[7:0];
					`GPC_OFF_SET: n.dout[a_base +: 8] = s.dout[a_base +: 8] | pwdata[7:0];
					`GPC_OFF_CLR: n.dout[a_base +: 8] = s.dout[a_base +: 8] & ~pwdata[7:0];
					`GPC_OFF_WAKE: n.wake[a_base +: 8] = pwdata[7:0];
					default: n.wake = s.wake;
				endcase
			end
		end
		// startup delay, then boot pin sample
		case (s.phase)
			PH_BOOT: begin
				if (s.boot_cnt == BOOT_LAST) begin
					n.boot_st = s.sync2[`GPC_PIN_PA5];
					n.phase = PH_RUN;
				end else begin
					n.boot_cnt = s.boot_cnt + 10'd1;
				end
			end
			PH_RUN: n.phase = PH_RUN;
			default: n.phase = PH_RUN;
		endcase
		// pin drivers
		dbg = !s.dbg_dis;
		jtag = dbg && dbg_jtag_active;
		swd = dbg && dbg_swd_active && !dbg_jtag_active;
		for (int i = 0; i < 24; i++) begin
			m = s.mode[i];
			av = alt_val(i, alt_out, timer_two_ch, timer_two_channel_enable_reg, timer_two_option_reg,
				trace_sel, trc);
			po = 1'b0;
			oe = 1'b0;
			pu = 1'b0;
			pd = 1'b0;
			an = 1'b0;
			case (m)
				`GPC_MODE_ANALOG: an = 1'b1;
				`GPC_MODE_FLOAT: an = 1'b0;
				`GPC_MODE_PULL: begin
					pu = s.dout[i];
					pd = !s.dout[i];
				end
				`GPC_MODE_PP: begin
					po = s.dout[i];
					oe = 1'b1;
				end
				`GPC_MODE_OD: oe = !s.dout[i];
				`GPC_MODE_ALT_PP, `GPC_MODE_SPI_CLK: begin
					po = av;
					oe = 1'b1;
				end
				`GPC_MODE_ALT_OD: oe = !av;
				default: an = 1'b0;
			endcase
			if (i == `GPC_PIN_PA7 && s.extreg) begin
				{po, oe, pu, pd, an} = {1'b0, !reg_en, 3'b000};
			end
			if (jtag && (i == `GPC_PIN_PC0 || i == `GPC_PIN_PC3 || i == `GPC_PIN_PC4)) begin
				{po, oe, pu, pd, an} = 5'b00100;
			end
			if (jtag && i == `GPC_PIN_PC2) begin
				{po, oe, pu, pd, an} = {test_data_output, 4'b1000};
			end
			if (swd && i == `GPC_PIN_PC4) begin
				{po, oe, pu, pd, an} = {swdio_out, swdio_oe, 3'b000};
			end
			if (s.phase == PH_BOOT && i == `GPC_PIN_PA5) begin
				{po, oe, pu, pd, an} = 5'b00100;
			end
			n.pin_out[i] = po;
			n.pin_oe[i] = oe;
			n.pull_up[i] = pu;
			n.pull_dn[i] = pd;
			n.analog[i] = an;
			n.periph_in[i] = an ? 1'b1 : s.sync2[i];
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s <= '0;
			s.phase <= PH_BOOT;
			s.mode <= {24{`GPC_CFG_RST}};
			s.extreg <= `GPC_EXTREG_RST;
			s.dbg_dis <= `GPC_DBGDIS_RST;
			s.boot_st <= `GPC_BOOT_RST;
			s.pull_up <= `GPC_PULL_RST;
		end else if (ce) begin
			s <= n;
		end
	end

	assign prdata = s.prdata;
	assign pready = s.pready;
	assign pslverr = s.pslverr;
	assign pin_out = s.pin_out;
	assign pin_oe = s.pin_oe;
	assign pin_pull_up = s.pull_up;
	assign pin_pull_down = s.pull_dn;
	assign pin_analog = s.analog;
	assign periph_in = s.periph_in;
	assign port_wake_monitor = s.wake;
	assign boot_select_status_bit = s.boot_st;

	// checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	logic wr_set;
	logic wr_clr;
	logic [23:0] wmask;
	assign wr_set = wr && a_port != `GPC_GLOBAL_SEL && a_off == `GPC_OFF_SET;
	assign wr_clr = wr && a_port != `GPC_GLOBAL_SEL && a_off == `GPC_OFF_CLR;
	assign wmask = 24'(pwdata[7:0]) << a_base;

	property p_analog_in;
		(ce && s.mode[`GPC_PIN_PB0] == `GPC_MODE_ANALOG) |=>
			(s.periph_in[`GPC_PIN_PB0] && s.analog[`GPC_PIN_PB0] && !s.pin_oe[`GPC_PIN_PB0]);
	endproperty
	a_analog_in: assert property (p_analog_in) else $error("analog pin not reading one");

	property p_float;
		(ce && s.mode[1] == `GPC_MODE_FLOAT) |=> (!s.pin_oe[1] && !s.pull_up[1] && !s.pull_dn[1]);
	endproperty
	a_float: assert property (p_float) else $error("floating input drives or pulls");

	property p_pull;
		(ce && s.mode[`GPC_PIN_PB0] == `GPC_MODE_PULL) |=>
			(s.pull_up[`GPC_PIN_PB0] == $past(s.dout[`GPC_PIN_PB0]) && s.pull_dn[`GPC_PIN_PB0] != s.pull_up[`GPC_PIN_PB0]);
	endproperty
	a_pull: assert property (p_pull) else $error("pull direction wrong");

	property p_pp;
		(ce && s.mode[`GPC_PIN_PB0] == `GPC_MODE_PP) |=>
			(s.pin_oe[`GPC_PIN_PB0] && s.pin_out[`GPC_PIN_PB0] == $past(s.dout[`GPC_PIN_PB0]));
	endproperty
	a_pp: assert property (p_pp) else $error("push-pull pin not following output");

	property p_set;
		(ce && wr_set) |=> ((s.dout & $past(wmask)) == $past(wmask));
	endproperty
	a_set: assert property (p_set) else $error("set write missed a bit");

	property p_clr_keep;
		(ce && wr_clr) |=> (s.dout == ($past(s.dout) & ~$past(wmask)));
	endproperty
	a_clr_keep: assert property (p_clr_keep) else $error("clear write disturbed other bits");

	property p_extreg;
		(ce && s.extreg) |=> (!s.pin_out[7] && s.pin_oe[7] == !$past(reg_en));
	endproperty
	a_extreg: assert property (p_extreg) else $error("regulator pin not forced");

	property p_jtag_tdo;
		(ce && !s.dbg_dis && dbg_jtag_active) |=> (s.pin_oe[18] && s.pin_out[18] == $past(test_data_output));
	endproperty
	a_jtag_tdo: assert property (p_jtag_tdo) else $error("test data output not forced");

	property p_boot_pull;
		(ce && s.phase == PH_BOOT) |=> s.pull_up[5] ##1 (s.phase == PH_BOOT || s.boot_cnt == BOOT_LAST);
	endproperty
	a_boot_pull: assert property (p_boot_pull) else $error("boot pin not pulled up");

	property p_boot_len;
		$changed(s.phase) |-> ($past(s.boot_cnt) == BOOT_LAST && s.boot_st == $past(s.sync2[5]));
	endproperty
	a_boot_len: assert property (p_boot_len) else $error("boot sample at wrong time");

	property p_apb_answer;
		(ce && psel && penable && !s.pready) |=> s.pready ##1 (!s.pready || !$past(ce));
	endproperty
	a_apb_answer: assert property (p_apb_answer) else $error("apb answer timing wrong");

	c_set: cover property (ce && wr_set);
	c_boot_done: cover property ($changed(s.phase));
	c_jtag: cover property (ce && !s.dbg_dis && dbg_jtag_active);
	c_unmapped: cover property (s.pslverr);

endmodule

/* testbench/gpc_pin_model.sv */
// pad model: resolves each pad from the block and an outside driver
// assumes the block's own drive wins over the outside driver
`timescale 1ns/1ps
module gpc_pin_model (
	// from block
	input wire logic clk,
	input wire logic [23:0] pin_out,
	input wire logic [23:0] pin_oe,
	input wire logic [23:0] pin_pull_up,
	input wire logic [23:0] pin_pull_down,
	// outside driver
	input wire logic [23:0] ext_drv,
	input wire logic [23:0] ext_en,
	// to block
	output logic [23:0] pin_in
);
	logic [23:0] flt = 24'h55_5555;
	// undriven pads wander every cycle
	always_ff @(posedge clk) begin
		flt <= ~flt;
	end
	always_comb begin
		for (int i = 0; i < 24; i++) begin
			if (pin_oe[i])
				pin_in[i] = pin_out[i];
			else if (ext_en[i])
				pin_in[i] = ext_drv[i];
			else if (pin_pull_up[i] | pin_pull_down[i])
				pin_in[i] = pin_pull_up[i];
			else
				pin_in[i] = flt[i];
		end
	end
endmodule

/* testbench/tb_gpc_port.sv */
// bench for the three-port pin controller
// assumes the pad model on the pins and an apb master in here
`timescale 1ns/1ps
module tb_gpc_port;
	logic clk, rst, ce, psel, penable, pwrite, pready, pslverr, boot_select_status_bit, e;
	logic [11:0] paddr;
	logic [31:0] pwdata, prdata, r;
	logic [23:0] pin_in, pin_out, pin_oe, pin_pull_up, pin_pull_down, pin_analog;
	logic [23:0] alt_out, periph_in, port_wake_monitor, ext_drv, ext_en;
	logic [3:0] timer_two_ch, timer_two_channel_enable_reg, timer_two_option_reg;
	logic trace_sel, packet_trace_enable, packet_trace_data, cpu_trace_data_bit_two, cpu_trace_data_bit_three;
	logic dbg_jtag_active, dbg_swd_active, test_data_output, swdio_out, swdio_oe, reg_en;
	int n_fail, num_checks;
	// mode, output bit, alt bit, then oe, drive, pull up, pull down, analog, input register
	logic [11:0] rows [0:10] = '{{4'h0, 2'b00, 6'h03}, {4'h4, 2'b00, 6'h00}, {4'h8, 2'b10, 6'h08},
		{4'h8, 2'b00, 6'h04}, {4'h1, 2'b10, 6'h31}, {4'h5, 2'b10, 6'h00}, {4'h5, 2'b00, 6'h20},
		{4'h9, 2'b01, 6'h31}, {4'hd, 2'b00, 6'h20}, {4'hb, 2'b01, 6'h31}, {4'h1, 2'b00, 6'h20}};

	gpc_port #(.STARTUP_CYCLES(4), .ALT_PRESENT(24'h7f_ffff)) i_gpc_port (
		.clk, .rst, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
		.pin_in, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down, .pin_analog, .alt_out, .periph_in,
		.port_wake_monitor, .timer_two_ch, .timer_two_channel_enable_reg, .timer_two_option_reg,
		.trace_sel, .packet_trace_enable, .packet_trace_data, .cpu_trace_data_bit_two,
		.cpu_trace_data_bit_three, .dbg_jtag_active, .dbg_swd_active, .test_data_output, .swdio_out,
		.swdio_oe, .reg_en, .boot_select_status_bit);
	gpc_pin_model i_gpc_pin_model (.clk, .pin_out, .pin_oe, .pin_pull_up, .pin_pull_down, .ext_drv, .ext_en, .pin_in);

	task automatic final_report;
		$display("checks %0d mismatches %0d", num_checks, n_fail);
		if (n_fail == 0 && num_checks > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	// one apb transfer, held until pready
	task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
		int n = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			n++;
		end while (pready !== 1'b1 && n < 50);
		r = prdata;
		e = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (n >= 50) begin
			n_fail++;
			final_report();
		end
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		apb(1'b1, a, d);
	endtask

	task automatic rd(input logic [11:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h0000_0000);
		chk(r, exp);
	endtask

	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end

	initial begin
		{psel, penable, pwrite, paddr, pwdata, alt_out, ext_drv} = '0;
		{timer_two_ch, timer_two_channel_enable_reg, timer_two_option_reg, trace_sel, packet_trace_enable} = '0;
		{packet_trace_data, cpu_trace_data_bit_two, cpu_trace_data_bit_three, dbg_jtag_active} = '0;
		{dbg_swd_active, test_data_output, swdio_out, swdio_oe, reg_en} = '0;
		{ce, rst, ext_en} = {2'b11, 24'h00_0020};
		n_fail = 0;
		num_checks = 0;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		@(posedge clk);
		#1;
		chk({29'h0, pin_pull_up[5], pin_oe[7], pin_out[7]}, 32'h0000_0006);
		rd(12'h000, 32'h0000_4444);
		rd(12'h060, 32'h0000_0002);
		chk({30'h0, boot_select_status_bit, pin_pull_up[5]}, 32'h0000_0000);
		rd(12'h064, 32'h0000_0000);
		ext_en <= 24'h00_0100;
		reg_en <= 1'b1;
		repeat (3) @(posedge clk);
		chk({31'h0, pin_oe[7]}, 32'h0000_0000);
		$display("test reset done");
		for (int i = 0; i < 11; i++) begin
			wr(12'h020, {28'h0, rows[i][11:8]});
			wr(12'h02c, {31'h0, rows[i][7]});
			alt_out[8] <= rows[i][6];
			repeat (6) @(posedge clk);
			apb(1'b0, 12'h028, 32'h0000_0000);
			chk({25'h0, pin_oe[8], pin_oe[8] & pin_out[8], pin_pull_up[8], pin_pull_down[8], pin_analog[8],
				r[0], periph_in[8]}, {25'h0, rows[i][5:0], rows[i][0]});
		end
		$display("test modes done");
		wr(12'h020, 32'h0000_1111);
		wr(12'h02c, 32'h0000_000f);
		wr(12'h030, 32'h0000_0030);
		rd(12'h02c, 32'h0000_003f);
		wr(12'h034, 32'h0000_0005);
		rd(12'h02c, 32'h0000_003a);
		chk({28'h0, pin_out[11:8]}, 32'h0000_000a);
		apb(1'b0, 12'h080, 32'h0000_0000);
		chk({e, r[30:0]}, 32'h8000_0000);
		wr(12'h058, 32'h0000_00a5);
		rd(12'h058, 32'h0000_00a5);
		chk({8'h0, port_wake_monitor}, 32'h00a5_0000);
		$display("test set clear done");
		wr(12'h044, 32'h0000_9444);
		alt_out <= 24'h80_0000;
		repeat (3) @(posedge clk);
		chk({30'h0, pin_oe[23], pin_out[23]}, 32'h0000_0002);
		wr(12'h000, 32'h0000_4449);
		wr(12'h020, 32'h0000_4494);
		timer_two_ch <= 4'hf;
		timer_two_channel_enable_reg <= 4'hf;
		repeat (3) @(posedge clk);
		chk({30'h0, pin_out[9], pin_out[0]}, 32'h0000_0001);
		timer_two_option_reg <= 4'hf;
		repeat (3) @(posedge clk);
		chk({30'h0, pin_out[9], pin_out[0]}, 32'h0000_0002);
		wr(12'h004, 32'h0000_4499);
		packet_trace_enable <= 1'b1;
		cpu_trace_data_bit_three <= 1'b1;
		repeat (3) @(posedge clk);
		chk({30'h0, pin_out[5], pin_out[4]}, 32'h0000_0001);
		trace_sel <= 1'b1;
		repeat (3) @(posedge clk);
		chk({30'h0, pin_out[5], pin_out[4]}, 32'h0000_0002);
		$display("test alternate done");
		dbg_jtag_active <= 1'b1;
		test_data_output <= 1'b1;
		repeat (3) @(posedge clk);
		chk({27'h0, pin_pull_up[16], pin_pull_up[19], pin_pull_up[20], pin_oe[18], pin_out[18]}, 32'h0000_001f);
		dbg_jtag_active <= 1'b0;
		{dbg_swd_active, swdio_oe, swdio_out} <= 3'b111;
		repeat (3) @(posedge clk);
		chk({30'h0, pin_oe[20], pin_out[20]}, 32'h0000_0003);
		wr(12'h060, 32'h0000_0003);
		repeat (3) @(posedge clk);
		chk({31'h0, pin_oe[20]}, 32'h0000_0000);
		ce <= 1'b0;
		reg_en <= 1'b0;
		repeat (3) @(posedge clk);
		chk({31'h0, pin_oe[7]}, 32'h0000_0000);
		ce <= 1'b1;
		repeat (3) @(posedge clk);
		chk({31'h0, pin_oe[7]}, 32'h0000_0001);
		$display("test debug done");
		ext_en <= 24'h00_0000;
		rst <= 1'b1;
		repeat (2) @(posedge clk);
		rst <= 1'b0;
		repeat (10) @(posedge clk);
		chk({31'h0, boot_select_status_bit}, 32'h0000_0001);
		rd(12'h064, 32'h0000_0001);
		rd(12'h060, 32'h0000_0002);
		rd(12'h044, 32'h0000_4444);
		$display("test second reset done");
		final_report();
	end
endmodule
